//--- logic/lip_pkg.sv
// Functional notes
// R1: Indicator changes only via indicator commands
// R2: 0xAC indicator off; 0xAD on, opens pair
// R3: After 0xAD only register set accepted
// R4: Register set byte ends the lock
// R5: Low two bits set blink mode
// R6: 0xA8 stand-by, 0xA9 sleep
// R7: Power save keeps settings and RAM access
// R8: Sleep stops oscillator and LCD supply
// R9: Sleep stops all drive, outputs high
// R10: Stand-by stops supply, oscillator runs
// R11: Stand-by stops duty drive, indicator runs
// R12: Blanking output low in power save
// R13: System may cut external supplies then
// R14: 0xE1 leaves power save, restores state
// R15: 0x3N loads line-reversal count N
// R16: 0xE4 returns to two-frame alternation
// R17: Reversal reset keeps stored count
// R18: Oscillator start needs master and internal clock
// R19: Oscillator start is byte 0xAB
// R20: 0xE3 is a no-operation
package lip_pkg;

  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_IND_OFF = 8'hAC;
  localparam logic [7:0] CMD_IND_ON = 8'hAD;
  localparam logic [7:0] CMD_STANDBY = 8'hA8;
  localparam logic [7:0] CMD_SLEEP = 8'hA9;
  localparam logic [7:0] CMD_PS_RELEASE = 8'hE1;
  localparam logic [7:0] CMD_REV_RESET = 8'hE4;
  localparam logic [7:0] CMD_OSC_START = 8'hAB;
  localparam logic [7:0] CMD_NOP = 8'hE3;
  localparam logic [3:0] CMD_REV_SET_HI = 4'h3;

  // ==========================================================
  // Field positions and reset values
  localparam int IND_MODE_LSB = 0;
  localparam int REV_N_LSB = 0;
  localparam logic [1:0] IND_MODE_RST = 2'h0;
  localparam logic [3:0] REV_N_RST = 4'h0;

  // Power state enumeration
  typedef enum logic [1:0] {
    LIP_RUN,
    LIP_STANDBY,
    LIP_SLEEP
  } lip_pwr_t;

endpackage

//--- logic/lip_cmd.sv
`timescale 1ns/1ps
module lip_cmd (
  input wire logic REF_CLK_I, // 40 MHz clock
  input wire logic RST_B_I, // Async reset, active low
  input wire logic WR_STB_I, // One-cycle byte write strobe
  input wire logic COMMAND_DATA_SELECT_I, // Low for command bytes
  input wire logic [7:0] DATA_I, // Written byte
  input wire logic MASTER_SEL_I, // High for master operation
  input wire logic CLOCK_SOURCE_SELECT_IN_I, // High for built-in oscillator
  output logic IND_ON_O, // Indicator enabled
  output logic [1:0] IND_MODE_O, // Indicator blink mode
  output logic IND_LOCK_O, // Waiting for indicator register byte
  output logic IND_DRIVE_EN_O, // Static indicator drive enable
  output logic DUTY_DRIVE_EN_O, // Multiplexed drive enable
  output logic OSC_EN_O, // Internal oscillator enable
  output logic LCD_SUPPLY_EN_O, // LCD power supply enable
  output logic DISPLAY_BLANK_OUT_O, // Low in power save
  output logic SLEEP_O, // Sleep state
  output logic STANDBY_O, // Stand-by state
  output logic [3:0] REV_N_O, // Stored line-reversal count
  output logic REV_EN_O // N-line alternation active
);

  // ==========================================================
  // Command kinds
  // One decoded kind per accepted byte; the register update then
  // only has to look at the kind, never at raw byte patterns.
  // Data bytes and idle cycles both map to the empty kind.
  typedef enum logic [3:0] {
    KIND_NONE,
    KIND_IND_OFF,
    KIND_IND_ON,
    KIND_IND_SET,
    KIND_STANDBY,
    KIND_SLEEP,
    KIND_RELEASE,
    KIND_REV_SET,
    KIND_REV_RESET,
    KIND_OSC_START,
    KIND_NOP,
    KIND_OTHER
  } lip_kind_t;

  // ==========================================================
  // State
  // Everything the block remembers sits in this one record. The
  // power state is kept apart from the settings so that leaving
  // power save gives back exactly what was there before.
  typedef struct packed {
    logic ind_on; // Indicator enabled
    logic [1:0] ind_mode; // Indicator blink code
    logic lock; // Only the register set byte is taken
    lip_pkg::lip_pwr_t pwr; // Run, stand-by or sleep
    logic osc_run; // Oscillator has been started
    logic [3:0] rev_n; // Stored line-reversal count
    logic rev_en; // N-line alternation selected
  } lip_state_t;

  lip_state_t st;
  lip_state_t next_st;
  logic cmd;
  lip_kind_t kind;
  logic osc_ok;
  logic in_run;
  logic in_sleep;
  logic in_standby;

  // ==========================================================
  // Helper functions

  // A byte is a command when it is strobed with the select low;
  // bytes written with the select high belong to display data.
  function automatic logic is_command(input logic stb, input logic sel);
    return stb && !sel;
  endfunction

  // Upper nibble 0x3 marks the line-reversal count byte
  function automatic logic is_rev_set(input logic [7:0] b);
    return b[7:4] == lip_pkg::CMD_REV_SET_HI;
  endfunction

  // Blink code carried in the low bits of the register set byte
  function automatic logic [1:0] ind_mode_of(input logic [7:0] b);
    return b[lip_pkg::IND_MODE_LSB +: 2];
  endfunction

  // Line-reversal count carried in the low nibble
  function automatic logic [3:0] rev_count_of(input logic [7:0] b);
    return b[lip_pkg::REV_N_LSB +: 4];
  endfunction

  // A count of zero selects no n-line alternation
  function automatic logic rev_enable_of(input logic [3:0] n);
    return n != 4'h0;
  endfunction

  // The oscillator start only counts for a master on the internal clock
  function automatic logic osc_allowed(input logic ms, input logic clock_source_select_in);
    return ms && clock_source_select_in;
  endfunction

  // Power state decodes, shared by several outputs
  function automatic logic pwr_is_run(input lip_pkg::lip_pwr_t p);
    return p == lip_pkg::LIP_RUN;
  endfunction

  function automatic logic pwr_is_sleep(input lip_pkg::lip_pwr_t p);
    return p == lip_pkg::LIP_SLEEP;
  endfunction

  function automatic logic pwr_is_standby(input lip_pkg::lip_pwr_t p);
    return p == lip_pkg::LIP_STANDBY;
  endfunction

  // Byte to command kind. While the lock is open every command byte is
  // the indicator register set, whatever its value, so the lock is
  // tested before anything else, the 0x3N form included.
  function automatic lip_kind_t decode_kind(input logic [7:0] b, input logic locked);
    lip_kind_t k;
    k = KIND_OTHER;
    if (locked) begin
      k = KIND_IND_SET; // R3 R4
    end else if (is_rev_set(b)) begin
      k = KIND_REV_SET; // R15
    end else begin
      case (b)
        lip_pkg::CMD_IND_OFF: begin
          k = KIND_IND_OFF; // R2
        end
        lip_pkg::CMD_IND_ON: begin
          k = KIND_IND_ON; // R2
        end
        lip_pkg::CMD_STANDBY: begin
          k = KIND_STANDBY; // R6
        end
        lip_pkg::CMD_SLEEP: begin
          k = KIND_SLEEP; // R6
        end
        lip_pkg::CMD_PS_RELEASE: begin
          k = KIND_RELEASE; // R14
        end
        lip_pkg::CMD_REV_RESET: begin
          k = KIND_REV_RESET; // R16
        end
        lip_pkg::CMD_OSC_START: begin
          k = KIND_OSC_START; // R19
        end
        lip_pkg::CMD_NOP: begin
          k = KIND_NOP; // R20
        end
        default: begin
          k = KIND_OTHER;
        end
      endcase
    end
    return k;
  endfunction

  // ==========================================================
  // Next-state helpers

  // Power state after a command. Entering one power save state from
  // the other is allowed; release while running changes nothing.
  function automatic lip_pkg::lip_pwr_t pwr_after(input lip_pkg::lip_pwr_t p, input lip_kind_t k);
    lip_pkg::lip_pwr_t n;
    n = p;
    case (k)
      KIND_STANDBY: begin
        n = lip_pkg::LIP_STANDBY; // R6
      end
      KIND_SLEEP: begin
        n = lip_pkg::LIP_SLEEP; // R6
      end
      KIND_RELEASE: begin
        n = lip_pkg::LIP_RUN; // R14
      end
      default: begin
        n = p; // R7
      end
    endcase
    return n;
  endfunction

  // Indicator on flag, moved only by the indicator commands
  function automatic logic ind_on_after(input logic on, input lip_kind_t k);
    logic n;
    n = on;
    case (k)
      KIND_IND_OFF: begin
        n = 1'h0; // R2
      end
      KIND_IND_ON: begin
        n = 1'h1; // R2
      end
      default: begin
        n = on; // R1
      end
    endcase
    return n;
  endfunction

  // Lock opens on the indicator on byte and closes on the next command
  function automatic logic lock_after(input logic lk, input lip_kind_t k);
    logic n;
    n = lk;
    case (k)
      KIND_IND_ON: begin
        n = 1'h1; // R3
      end
      KIND_IND_SET: begin
        n = 1'h0; // R4
      end
      default: begin
        n = lk;
      end
    endcase
    return n;
  endfunction

  // N-line alternation: set by a nonzero count byte, cleared by a zero count or the reset byte
  function automatic logic rev_en_after(input logic en, input lip_kind_t k, input logic [7:0] b);
    logic n;
    n = en;
    case (k)
      KIND_REV_SET: begin
        n = rev_enable_of(rev_count_of(b)); // R15
      end
      KIND_REV_RESET: begin
        n = 1'h0; // R16
      end
      default: begin
        n = en;
      end
    endcase
    return n;
  endfunction

  // Oscillator run flag: an allowed start sets it, nothing clears it
  function automatic logic osc_after(input logic run, input lip_kind_t k, input logic ok);
    logic n;
    n = run;
    if (k == KIND_OSC_START && ok) begin
      n = 1'h1; // R18
    end
    return n;
  endfunction

  // Blink code: only the register set byte loads it
  function automatic logic [1:0] mode_after(input logic [1:0] m, input lip_kind_t k, input logic [7:0] b);
    logic [1:0] n;
    n = m;
    if (k == KIND_IND_SET) begin
      n = ind_mode_of(b); // R5
    end
    return n;
  endfunction

  // Stored count: only a count byte loads it, the reset byte keeps it
  function automatic logic [3:0] rev_n_after(input logic [3:0] c, input lip_kind_t k, input logic [7:0] b);
    logic [3:0] n;
    n = c;
    if (k == KIND_REV_SET) begin
      n = rev_count_of(b); // R15 R17
    end
    return n;
  endfunction

  // ==========================================================
  // Command decode

  // Qualify the strobe and classify the byte in the same cycle
  assign cmd = is_command(WR_STB_I, COMMAND_DATA_SELECT_I);
  assign kind = cmd ? decode_kind(DATA_I, st.lock) : KIND_NONE;
  assign osc_ok = osc_allowed(MASTER_SEL_I, CLOCK_SOURCE_SELECT_IN_I); // R18

  // Next state, field by field. Fields a command does not name carry
  // over, which keeps settings intact across power save and makes
  // unknown bytes and data bytes harmless.
  always_comb begin
    next_st = st;
    next_st.ind_on = ind_on_after(st.ind_on, kind); // R1 R2
    next_st.lock = lock_after(st.lock, kind); // R3 R4
    next_st.ind_mode = mode_after(st.ind_mode, kind, DATA_I); // R5
    next_st.pwr = pwr_after(st.pwr, kind); // R6 R7 R14
    next_st.rev_n = rev_n_after(st.rev_n, kind, DATA_I); // R15 R17
    next_st.rev_en = rev_en_after(st.rev_en, kind, DATA_I); // R15 R16
    next_st.osc_run = osc_after(st.osc_run, kind, osc_ok); // R18 R19
  end

  // ==========================================================
  // State register

  // Reset puts the block in run with every setting cleared and the
  // oscillator stopped until it is started by command.
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st.ind_on <= 1'h0;
      st.ind_mode <= lip_pkg::IND_MODE_RST;
      st.lock <= 1'h0;
      st.pwr <= lip_pkg::LIP_RUN;
      st.osc_run <= 1'h0;
      st.rev_n <= lip_pkg::REV_N_RST;
      st.rev_en <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Power view

  // Decoded once and shared by the outputs below
  assign in_run = pwr_is_run(st.pwr);
  assign in_sleep = pwr_is_sleep(st.pwr);
  assign in_standby = pwr_is_standby(st.pwr);

  // ==========================================================
  // Outputs

  // Settings as stored; power save leaves them alone
  assign IND_ON_O = st.ind_on;
  assign IND_MODE_O = st.ind_mode;
  assign IND_LOCK_O = st.lock;
  assign REV_N_O = st.rev_n;
  assign REV_EN_O = st.rev_en;

  // Power state flags
  assign SLEEP_O = in_sleep;
  assign STANDBY_O = in_standby;

  // Oscillator stops in sleep and runs on in stand-by
  assign OSC_EN_O = st.osc_run && !in_sleep; // R8 R10

  // LCD supply only in run
  assign LCD_SUPPLY_EN_O = in_run; // R8 R10

  // Duty drive stops in either power save state
  assign DUTY_DRIVE_EN_O = in_run; // R9 R11

  // Static indicator drive stops in sleep only, so stand-by
  // still shows the indicator at minimum current
  assign IND_DRIVE_EN_O = st.ind_on && !in_sleep; // R9 R11

  // Blanking output goes low on entering power save, so it can
  // switch off external supplies
  assign DISPLAY_BLANK_OUT_O = in_run; // R12

endmodule

//--- verif/lip_cmd_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Command decode checks
module lip_cmd_properties (
  input wire logic REF_CLK_I, RST_B_I, WR_STB_I, COMMAND_DATA_SELECT_I, IND_ON_O, IND_LOCK_O, IND_DRIVE_EN_O,
  input wire logic DUTY_DRIVE_EN_O, OSC_EN_O, LCD_SUPPLY_EN_O, DISPLAY_BLANK_OUT_O, SLEEP_O, STANDBY_O, REV_EN_O,
  input wire logic MASTER_SEL_I, CLOCK_SOURCE_SELECT_IN_I,
  input wire logic [7:0] DATA_I, input wire logic [1:0] IND_MODE_O, input wire logic [3:0] REV_N_O);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_B_I);
  // Low bits of the byte and a command taken outside the lock
  wire logic [1:0] set_bits = DATA_I[1:0];
  wire logic [3:0] rev_bits = DATA_I[3:0];
  sequence rev_byte;
    WR_STB_I && !COMMAND_DATA_SELECT_I && !IND_LOCK_O && DATA_I[7:4] == 4'h3;
  endsequence
  sequence osc_cmd(ok);
    WR_STB_I && !COMMAND_DATA_SELECT_I && !IND_LOCK_O && DATA_I == 8'hAB && (MASTER_SEL_I && CLOCK_SOURCE_SELECT_IN_I) == ok;
  endsequence
  sequence cmd(b);
    WR_STB_I && !COMMAND_DATA_SELECT_I && !IND_LOCK_O && DATA_I == b;
  endsequence
  a_ind_off: assert property (cmd(8'hAC) |=> !IND_ON_O && !IND_LOCK_O) else $error("ind off");
  a_lock_open: assert property (cmd(8'hAD) |=> IND_ON_O && IND_LOCK_O) else $error("lock");
  a_lock_end: assert property (IND_LOCK_O && WR_STB_I && !COMMAND_DATA_SELECT_I |=>
    !IND_LOCK_O && IND_MODE_O == $past(set_bits)) else $error("ind mode");
  a_sleep_enter: assert property (cmd(8'hA9) |=> SLEEP_O && !STANDBY_O) else $error("sleep");
  a_sleep_stop: assert property (SLEEP_O |-> !(OSC_EN_O || LCD_SUPPLY_EN_O || IND_DRIVE_EN_O || DUTY_DRIVE_EN_O))
    else $error("sleep en");
  a_standby_run: assert property (STANDBY_O |-> !LCD_SUPPLY_EN_O && !DUTY_DRIVE_EN_O && IND_DRIVE_EN_O == IND_ON_O)
    else $error("standby en");
  a_blank_level: assert property (DISPLAY_BLANK_OUT_O != (SLEEP_O || STANDBY_O)) else $error("blank");
  a_rev_keep: assert property (cmd(8'hE4) |=> !REV_EN_O && $stable(REV_N_O)) else $error("rev");
  a_rev_set: assert property (rev_byte |=> REV_N_O == $past(rev_bits) && REV_EN_O == ($past(rev_bits) != 4'h0))
    else $error("rev set");
  a_standby_enter: assert property (cmd(8'hA8) |=> STANDBY_O && !SLEEP_O) else $error("standby");
  a_release_run: assert property (cmd(8'hE1) |=> !SLEEP_O && !STANDBY_O && $stable(IND_MODE_O))
    else $error("release");
  a_nop_hold: assert property (cmd(8'hE3) |=> $stable({IND_ON_O, IND_MODE_O, SLEEP_O, STANDBY_O, OSC_EN_O, REV_N_O}))
    else $error("nop");
  a_osc_start: assert property (osc_cmd(1'h1) ##0 !SLEEP_O |=> OSC_EN_O) else $error("osc start");
  a_osc_refused: assert property (osc_cmd(1'h0) ##0 !OSC_EN_O |=> !OSC_EN_O) else $error("osc refused");
endmodule
bind lip_cmd lip_cmd_properties lip_cmd_properties_inst (.*);

//--- verif/lip_host.sv
`timescale 1ns/1ps
// ==========================================================
// Host byte writer
module lip_host (
  input wire logic REF_CLK_I, // Clock
  input wire logic DISPLAY_BLANK_OUT_O, // Blanking output of the block
  output logic EXT_SUPPLY_ON_O, // External LCD supply running
  output logic WR_STB_I = 1'h0, // Byte strobe
  output logic COMMAND_DATA_SELECT_I = 1'h1, // Low for commands
  output logic [7:0] DATA_I = 8'h00 // Byte
);
  // External supply follows the blanking output, cut in power save
  assign EXT_SUPPLY_ON_O = DISPLAY_BLANK_OUT_O;
  // One strobed byte, then the released data lines show the inverse
  task send(input logic [7:0] b, input logic cd);
    @(posedge REF_CLK_I);
    WR_STB_I <= 1;
    COMMAND_DATA_SELECT_I <= cd;
    DATA_I <= b;
    @(posedge REF_CLK_I);
    WR_STB_I <= 0;
    DATA_I <= ~b;
  endtask
endmodule

//--- verif/lip_cmd_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Bench
module lip_cmd_tb;
  logic REF_CLK_I = 0, RST_B_I = 0, MASTER_SEL_I = 1, CLOCK_SOURCE_SELECT_IN_I = 0, WR_STB_I, COMMAND_DATA_SELECT_I;
  logic IND_ON_O, IND_LOCK_O, IND_DRIVE_EN_O, DUTY_DRIVE_EN_O, OSC_EN_O, LCD_SUPPLY_EN_O, DISPLAY_BLANK_OUT_O;
  logic SLEEP_O, STANDBY_O, REV_EN_O, EXT_SUPPLY_ON_O;
  logic [7:0] DATA_I;
  logic [1:0] IND_MODE_O;
  logic [3:0] REV_N_O;
  int n_errors = 0;
  int n_checks = 0;
  // Select, byte, then {on, mode, sleep, standby, blank, n-line, oscillator}
  logic [16:0] rows [15] = '{17'h0AD84, 17'h0A9A4, 17'h035A6, 17'h0A9B2, 17'h0E3B2, 17'h0A8AA, 17'h0E1A6,
    17'h0E4A4, 17'h0AC24, 17'h0AB25, 17'h0A930, 17'h0E125, 17'h1A925, 17'h0ADA5, 17'h0FFE5};
  lip_cmd lip_cmd_inst (.*);
  lip_host lip_host_inst (.*);
  always #12.5 REF_CLK_I = ~REF_CLK_I;
  // Compare and count
  task chk(input string n, input logic [11:0] e, input logic [11:0] s);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [7:0] seen();
    return {IND_ON_O, IND_MODE_O, SLEEP_O, STANDBY_O, DISPLAY_BLANK_OUT_O, REV_EN_O, OSC_EN_O};
  endfunction
  function automatic logic [7:0] en();
    return {IND_DRIVE_EN_O, DUTY_DRIVE_EN_O, LCD_SUPPLY_EN_O, OSC_EN_O,
      DISPLAY_BLANK_OUT_O, EXT_SUPPLY_ON_O, IND_MODE_O};
  endfunction
  // Reset, refused start, table, stored count
  initial begin
    repeat (6) @(posedge REF_CLK_I);
    RST_B_I <= 1;
    #1 chk("reset", 12'h013, {seen(), LCD_SUPPLY_EN_O, DUTY_DRIVE_EN_O});
    chk("reset lock", 12'h000, {IND_LOCK_O, IND_DRIVE_EN_O, REV_N_O});
    lip_host_inst.send(8'hAB, 0);
    #1 chk("osc", 8'h00, {7'h00, OSC_EN_O});
    @(posedge REF_CLK_I) CLOCK_SOURCE_SELECT_IN_I <= 1;
    foreach (rows[i]) begin
      lip_host_inst.send(rows[i][15:8], rows[i][16]);
      #1 chk("outputs", rows[i][7:0], seen());
    end
    chk("count", 8'h05, {4'h0, REV_N_O});
    // Lock takes a 0x3N byte as the register set and keeps the count
    lip_host_inst.send(8'hAD, 1'h0);
    #1 chk("lock", 12'h001, IND_LOCK_O);
    lip_host_inst.send(8'h32, 1'h0);
    #1 chk("lock set", 12'h025, {IND_LOCK_O, IND_MODE_O, REV_N_O});
    // Count range, reversal reset, zero count
    lip_host_inst.send(8'h3F, 1'h0);
    #1 chk("rev", 12'h01F, {REV_N_O, REV_EN_O});
    lip_host_inst.send(8'hE4, 1'h0);
    #1 chk("rev", 12'h01E, {REV_N_O, REV_EN_O});
    lip_host_inst.send(8'h30, 1'h0);
    #1 chk("rev", 12'h000, {REV_N_O, REV_EN_O});
    // Enables in stand-by, sleep and after release
    lip_host_inst.send(8'hA8, 1'h0);
    #1 chk("power", 12'h092, en());
    lip_host_inst.send(8'hA9, 1'h0);
    #1 chk("power", 12'h002, en());
    lip_host_inst.send(8'hE1, 1'h0);
    #1 chk("power", 12'h0FE, en());
    // Reset in mid-run clears an open lock and every setting
    lip_host_inst.send(8'hAD, 1'h0);
    @(posedge REF_CLK_I) RST_B_I <= 1'h0;
    repeat (2) @(posedge REF_CLK_I);
    RST_B_I <= 1'h1;
    #1 chk("reset", 12'h013, {seen(), LCD_SUPPLY_EN_O, DUTY_DRIVE_EN_O});
    chk("reset lock", 12'h000, {IND_LOCK_O, IND_DRIVE_EN_O, REV_N_O});
    report_and_stop;
  end
endmodule
